/* shared/rpc_pkg.sv */
// Shared constants and types for the reset and powerdown controller
package rpc_pkg;
    localparam int RST_MIN_LOW_CYCLES = 22;
    localparam logic [4:0] RST_CNT_TERMINAL = 5'h15;
    localparam logic [15:0] RESET_FETCH_ADDR = 16'h0020;
    localparam logic [15:0] VECTOR_AREA_TOP = 16'h00FF;
    localparam logic [7:0] OPC_STOP = 8'h7F;
    localparam logic [7:0] OPC_IDLE = 8'h6F;
    localparam int SRC_COUNT = 13;
    localparam int P2_WIDTH = 8;
    localparam int P4_WIDTH = 4;
    localparam int TMR_SRC = 12;
    localparam int LEVEL_COUNT = 3;
    localparam int OSC_MAX_KHZ = 5000;
    localparam int TMR_DIV = 1000;
    localparam logic [9:0] TMR_DIV_TERMINAL = 10'h3E7;
    localparam logic [7:0] STAB_DEFAULT = 8'hFF;

    typedef enum logic [1:0] {
        RPC_RUN = 2'b00,
        RPC_IDLE = 2'b01,
        RPC_STOP = 2'b11,
        RPC_STAB = 2'b10
    } rpc_state_t;

    typedef struct packed {
        logic [P2_WIDTH-1:0] p2;
        logic [P4_WIDTH-1:0] p4;
    } rpc_ext_irq_t;

    typedef struct packed {
        logic valid;
        logic [3:0] source;
        logic [1:0] level;
    } rpc_irq_sel_t;
endpackage

/* design/rpc_reset_filter.sv */
// Reset pin synchroniser and minimum low time filter
`timescale 1ns/1ps
module rpc_reset_filter
    import rpc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_reset_pin_n,
    output logic o_reset_valid
);
    logic sync_a;
    logic sync_b;
    logic [4:0] low_count;
    logic next_valid;

    // [RL20] Short pulse ignored
    assign next_valid = !sync_b && (low_count == RST_CNT_TERMINAL);

    // [RL2] Two-stage synchroniser
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
        end else if (i_ce) begin
            sync_a <= i_reset_pin_n;
            sync_b <= sync_a;
        end
    end

    // [RL1] Count 22 low cycles
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_count <= 5'h00;
            o_reset_valid <= 1'b0;
        end else if (i_ce) begin
            if (sync_b) begin
                low_count <= 5'h00;
            end else if (low_count != RST_CNT_TERMINAL) begin
                low_count <= low_count + 5'h01;
            end
            o_reset_valid <= next_valid;
        end
    end
endmodule

/* design/rpc_irq_arbiter.sv */
// Interrupt source prioritiser across three levels
`timescale 1ns/1ps
module rpc_irq_arbiter
    import rpc_pkg::*;
(
    input wire logic [SRC_COUNT-1:0] i_pending,
    input wire logic [2*SRC_COUNT-1:0] i_level_map,
    input wire logic [5:0] i_interrupt_priority_register,
    output rpc_irq_sel_t o_sel
);
    // Lowest numbered pending source on a level
    function automatic logic [4:0] pick(input logic [SRC_COUNT-1:0] pend,
                                        input logic [2*SRC_COUNT-1:0] map,
                                        input logic [1:0] lvl);
        logic [4:0] r;
        r = 5'h00;
        for (int k = SRC_COUNT - 1; k >= 0; k--) begin
            if (pend[k] && map[2*k +: 2] == lvl) begin
                r = {1'b1, 4'(k)};
            end
        end
        return r;
    endfunction

    wire [4:0] hit0 = pick(i_pending, i_level_map, i_interrupt_priority_register[1:0]);
    wire [4:0] hit1 = pick(i_pending, i_level_map, i_interrupt_priority_register[3:2]);
    wire [4:0] hit2 = pick(i_pending, i_level_map, i_interrupt_priority_register[5:4]);

    // [RL15] Register orders levels
    // [RL16] Lowest vector wins within level
    assign o_sel = hit0[4] ? {1'b1, hit0[3:0], i_interrupt_priority_register[1:0]} :
                   hit1[4] ? {1'b1, hit1[3:0], i_interrupt_priority_register[3:2]} :
                   hit2[4] ? {1'b1, hit2[3:0], i_interrupt_priority_register[5:4]} :
                   7'h00;
endmodule

/* design/rpc_top.sv */
// Reset, powerdown and wake-up control
// Summary of operation
// [RL1] Reset needs 22 consecutive low clocks
// [RL2] Reset pin synchronised before use
// [RL3] Fetch starts at 0020H after reset
// [RL4] Lowest 256 bytes hold vectors
// [RL5] Opcode 7FH enters Stop
// [RL6] Stop halts oscillator, CPU, peripherals
// [RL7] Register file kept during Stop
// [RL8] Stop ends on reset or port interrupt
// [RL9] Opcode 6FH enters Idle
// [RL10] Idle gates CPU clock only
// [RL11] Port directions held during Idle
// [RL12] System, control, data registers kept
// [RL13] Idle ends on reset, port, timer
// [RL14] Thirteen sources with own vectors
// [RL15] Priority register orders three levels
// [RL16] Same level: lowest vector first
// [RL17] Oscillator drives logic undivided
// [RL18] Stabilisation wait counts oscillator clock
// [RL19] Normal timer clock divided by 1000
// [RL20] Short reset ignored; reset overrides powerdown
// [RL21] Resume only after stabilisation expires
`timescale 1ns/1ps
module rpc_top
    import rpc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_reset_pin_n,
    input wire logic i_opcode_valid,
    input wire logic [7:0] i_opcode,
    input rpc_ext_irq_t i_ext_irq,
    input rpc_ext_irq_t i_ext_irq_enable,
    input wire logic i_timer_overflow,
    input wire logic i_irq_ack,
    input wire logic [2*SRC_COUNT-1:0] i_level_map,
    input wire logic [5:0] i_interrupt_priority_register,
    input wire logic [7:0] i_stab_count,
    output logic o_core_reset,
    output logic [15:0] o_fetch_addr,
    output logic o_fetch_load,
    output logic o_cpu_clk_en,
    output logic o_periph_clk_en,
    output logic o_osc_enable,
    output logic o_regfile_hold,
    output logic o_port_dir_hold,
    output logic o_timer_tick,
    output logic o_timer_osc_src,
    output logic o_irq_valid,
    output logic [3:0] o_irq_source,
    output logic [15:0] o_irq_vector,
    output logic [1:0] o_irq_level,
    output rpc_state_t o_state
);
    rpc_state_t state;
    rpc_state_t next_state;
    logic reset_valid;
    logic reset_seen;
    logic [SRC_COUNT-1:0] pending;
    logic [9:0] div_count;
    logic [7:0] stab_count;
    logic load_pending;
    rpc_irq_sel_t sel;

    // Vector slot per source inside the low page
    function automatic logic [15:0] vec_of(input logic [3:0] src);
        return {8'h00, 3'h0, src, 1'b0} & VECTOR_AREA_TOP;
    endfunction

    rpc_reset_filter u_filter (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_reset_pin_n(i_reset_pin_n),
        .o_reset_valid(reset_valid)
    );

    rpc_irq_arbiter u_arb (
        .i_pending(pending),
        .i_level_map(i_level_map),
        .i_interrupt_priority_register(i_interrupt_priority_register),
        .o_sel(sel)
    );

    wire [P2_WIDTH+P4_WIDTH-1:0] ext_hit = i_ext_irq & i_ext_irq_enable;
    wire ext_any = |ext_hit;
    wire in_stop = (state == RPC_STOP);
    wire in_stab = (state == RPC_STAB);
    wire in_idle = (state == RPC_IDLE);
    wire is_stop_op = i_opcode_valid && (i_opcode == OPC_STOP);
    wire is_idle_op = i_opcode_valid && (i_opcode == OPC_IDLE);
    wire div_wrap = (div_count == TMR_DIV_TERMINAL);
    wire stab_done = in_stab && (stab_count == 8'h00);
    wire timer_event = i_timer_overflow && !in_stop && !in_stab;
    // Timer request sits above the twelve port requests
    wire [SRC_COUNT-1:0] set_req = {timer_event, ext_hit};

    // [RL8] Only port interrupt wakes Stop
    // [RL13] Idle wakes on port or timer
    // [RL5] Stop opcode
    // [RL9] Idle opcode
    // [RL21] Hold until stabilisation done
    always_comb begin
        next_state = state;
        unique case (state)
            RPC_RUN: begin
                if (is_stop_op) begin
                    next_state = RPC_STOP;
                end else if (is_idle_op) begin
                    next_state = RPC_IDLE;
                end
            end
            RPC_IDLE: begin
                if (ext_any || i_timer_overflow) begin
                    next_state = RPC_RUN;
                end
            end
            RPC_STOP: begin
                if (ext_any) begin
                    next_state = RPC_STAB;
                end
            end
            RPC_STAB: begin
                if (stab_done) begin
                    next_state = RPC_RUN;
                end
            end
        endcase
    end

    // [RL20] Valid reset overrides powerdown
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= RPC_RUN;
            reset_seen <= 1'b1;
        end else if (i_ce) begin
            if (reset_valid) begin
                state <= RPC_RUN;
                reset_seen <= 1'b1;
            end else begin
                state <= next_state;
                reset_seen <= 1'b0;
            end
        end
    end

    // [RL18] Stabilisation counts oscillator clock
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stab_count <= STAB_DEFAULT;
        end else if (i_ce) begin
            if (in_stop) begin
                stab_count <= i_stab_count;
            end else if (in_stab && stab_count != 8'h00) begin
                stab_count <= stab_count - 8'h01;
            end
        end
    end

    // [RL19] Divide oscillator clock by 1000
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_count <= 10'h000;
        end else if (i_ce) begin
            if (in_stop || in_stab || reset_valid || div_wrap) begin
                div_count <= 10'h000;
            end else begin
                div_count <= div_count + 10'h001;
            end
        end
    end

    // [RL14] Thirteen pending sources; set wins over ack
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pending <= '0;
        end else if (i_ce) begin
            if (reset_valid) begin
                pending <= '0;
            end else begin
                for (int k = 0; k < SRC_COUNT; k++) begin
                    if (set_req[k]) begin
                        pending[k] <= 1'b1;
                    end else if (i_irq_ack && sel.valid && sel.source == 4'(k)) begin
                        pending[k] <= 1'b0;
                    end
                end
            end
        end
    end

    // [RL3] Reset fetch address
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fetch_addr <= RESET_FETCH_ADDR;
            o_fetch_load <= 1'b0;
            o_core_reset <= 1'b1;
            load_pending <= 1'b1;
        end else if (i_ce) begin
            o_core_reset <= reset_valid;
            if (reset_valid) begin
                load_pending <= 1'b1;
                o_fetch_load <= 1'b0;
            end else begin
                load_pending <= 1'b0;
                o_fetch_load <= load_pending;
            end
            o_fetch_addr <= RESET_FETCH_ADDR;
        end
    end

    // [RL4] Vectors in low page
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq_valid <= 1'b0;
            o_irq_source <= 4'h0;
            o_irq_vector <= 16'h0000;
            o_irq_level <= 2'h0;
        end else if (i_ce) begin
            o_irq_valid <= sel.valid && (state == RPC_RUN) && !reset_valid;
            o_irq_source <= sel.source;
            o_irq_vector <= vec_of(sel.source);
            o_irq_level <= sel.level;
        end
    end

    // [RL6] Stop halts oscillator and all
    // [RL10] Idle gates CPU only
    // [RL17] Undivided oscillator clock
    assign o_osc_enable = !in_stop;
    assign o_cpu_clk_en = (state == RPC_RUN) && !reset_seen;
    assign o_periph_clk_en = !in_stop && !in_stab;
    // [RL7] Register file held in Stop
    // [RL12] Registers held in Idle
    assign o_regfile_hold = in_stop || in_stab || in_idle;
    // [RL11] Port direction frozen in Idle
    assign o_port_dir_hold = in_idle || in_stop || in_stab;
    assign o_timer_tick = in_stab ? 1'b1 : (div_wrap && !in_stop);
    assign o_timer_osc_src = in_stab;
    assign o_state = state;
endmodule

/* sim/rpc_top_sva.sv */
// Port assertions for the reset and powerdown controller
`timescale 1ns/1ps
module rpc_top_chk
    import rpc_pkg::*;
(
    input logic i_clock,
    input logic i_rst_n,
    input logic i_ce,
    input logic i_reset_pin_n,
    input logic i_opcode_valid,
    input logic [7:0] i_opcode,
    input rpc_ext_irq_t i_ext_irq,
    input rpc_ext_irq_t i_ext_irq_enable,
    input logic i_timer_overflow,
    input logic [7:0] i_stab_count,
    input logic o_core_reset,
    input logic o_fetch_load,
    input logic o_cpu_clk_en,
    input logic o_periph_clk_en,
    input logic o_osc_enable,
    input logic o_regfile_hold,
    input logic o_port_dir_hold,
    input logic o_timer_tick,
    input logic o_timer_osc_src,
    input logic o_irq_valid,
    input logic [3:0] o_irq_source,
    input logic [15:0] o_irq_vector,
    input rpc_state_t o_state
);
    logic pin_q;
    logic [4:0] low_cnt;
    logic [8:0] stab_cnt;
    logic [7:0] stab_len;
    wire wake = |(i_ext_irq & i_ext_irq_enable);
    wire take = o_state == RPC_RUN && i_ce && i_opcode_valid && o_cpu_clk_en && !o_core_reset;
    wire [4:0] low_inc = low_cnt + {4'h0, low_cnt != 5'h1F};
    // Length of the latest low run on the pin, held after it ends
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_q <= 1'b1;
            low_cnt <= 5'h00;
            stab_cnt <= 9'h000;
            stab_len <= 8'h00;
        end else begin
            pin_q <= i_reset_pin_n;
            low_cnt <= i_reset_pin_n ? low_cnt : (pin_q ? 5'h01 : low_inc);
            stab_cnt <= (o_state == RPC_STAB) ? stab_cnt + 9'h001 : 9'h000;
            stab_len <= (o_state == RPC_STOP) ? i_stab_count : stab_len;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    sequence load_pulse;
        o_fetch_load ##1 !o_fetch_load;
    endsequence
    sequence stop_live;
        o_state == RPC_STOP && i_ce && !o_core_reset;
    endsequence
    chk_fetch_load: assert property ($fell(o_core_reset) |-> load_pulse)
        else $error("fetch load strobe misplaced");
    chk_reset_len: assert property ($rose(o_core_reset)
        |-> low_cnt >= RST_MIN_LOW_CYCLES) else $error("reset taken too early");
    chk_stop_entry: assert property (take && i_opcode == OPC_STOP
        |=> o_state == RPC_STOP || o_core_reset) else $error("stop not entered");
    chk_idle_entry: assert property (take && i_opcode == OPC_IDLE
        |=> o_state == RPC_IDLE || o_core_reset) else $error("idle not entered");
    chk_stop_gates: assert property (o_state == RPC_STOP |-> !o_osc_enable
        && !o_cpu_clk_en && !o_periph_clk_en && !o_timer_tick && o_regfile_hold)
        else $error("stop gating wrong");
    chk_idle_gates: assert property (o_state == RPC_IDLE |-> !o_cpu_clk_en
        && o_periph_clk_en && o_osc_enable && o_port_dir_hold && o_regfile_hold)
        else $error("idle gating wrong");
    chk_stop_hold: assert property ((stop_live ##0 !wake) |=>
        o_state == RPC_STOP || o_core_reset) else $error("stop left without cause");
    chk_stop_wake: assert property ((stop_live ##0 wake) |=>
        o_state == RPC_STAB || o_core_reset) else $error("stop wake missed");
    chk_idle_wake: assert property (o_state == RPC_IDLE && i_ce && !o_core_reset
        && (wake || i_timer_overflow) |=> o_state == RPC_RUN) else $error("idle wake missed");
    chk_stab_clock: assert property (o_state == RPC_STAB
        |-> o_timer_osc_src && o_timer_tick) else $error("timer not on oscillator");
    chk_stab_len: assert property (o_state == RPC_RUN && stab_cnt != 9'h000
        && !o_core_reset |-> stab_cnt == {1'b0, stab_len} + 9'h001)
        else $error("wait length wrong");
    chk_irq_vector: assert property (o_irq_valid
        |-> o_irq_vector <= VECTOR_AREA_TOP && o_irq_vector == {11'h000, o_irq_source, 1'b0})
        else $error("vector wrong");
endmodule
bind rpc_top rpc_top_chk u_rpc_chk (.*);

/* sim/rpc_pin_model.sv */
// Reset pin and port interrupt pin driver
`timescale 1ns/1ps
module rpc_pin_model
    import rpc_pkg::*;
(
    input wire logic i_clock,
    output logic o_reset_pin_n,
    output rpc_ext_irq_t o_ext_irq
);
    // Pin rests high on its pull-up
    initial begin
        o_reset_pin_n = 1'b1;
        o_ext_irq = '0;
    end
    task automatic hold_reset(input int cycles);
        @(negedge i_clock);
        o_reset_pin_n = 1'b0;
        repeat (cycles) @(negedge i_clock);
        o_reset_pin_n = 1'b1;
    endtask
    task automatic pulse_irq(input logic [11:0] pins);
        @(negedge i_clock);
        o_ext_irq = rpc_ext_irq_t'(pins);
        @(negedge i_clock);
        o_ext_irq = '0;
    endtask
endmodule

/* sim/reset_and_powerdown_control_test.sv */
// Self-checking bench for the reset and powerdown controller
`timescale 1ns/1ps
module reset_and_powerdown_control_test
    import rpc_pkg::*;
;
    logic i_clock, i_rst_n, i_ce, i_reset_pin_n, i_opcode_valid, i_timer_overflow, i_irq_ack;
    logic [7:0] i_opcode, i_stab_count;
    logic [2*SRC_COUNT-1:0] i_level_map;
    logic [5:0] i_interrupt_priority_register;
    rpc_ext_irq_t i_ext_irq, i_ext_irq_enable;
    logic o_core_reset, o_fetch_load, o_cpu_clk_en, o_periph_clk_en, o_osc_enable;
    logic o_regfile_hold, o_port_dir_hold, o_timer_tick, o_timer_osc_src, o_irq_valid;
    logic [15:0] o_fetch_addr, o_irq_vector;
    logic [3:0] o_irq_source;
    logic [1:0] o_irq_level;
    rpc_state_t o_state;
    logic [12:0] pend;
    logic [6:0] e;
    logic seen;
    logic [5:0] perm [6] = '{6'h24, 6'h18, 6'h21, 6'h09, 6'h12, 6'h06};
    int lens [4] = '{12, 21, 22, 40};
    int failures = 0;
    int total_checks = 0;
    int n;
    rpc_top DUT (.*);
    rpc_pin_model pins (.i_clock(i_clock), .o_reset_pin_n(i_reset_pin_n), .o_ext_irq(i_ext_irq));
    task automatic end_of_test;
        if (failures == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
        total_checks++;
        if (seen_v !== exp_v) begin
            failures++;
            $display("mismatch at %0t: saw %0h expected %0h", $time, seen_v, exp_v);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge i_clock);
    endtask
    task automatic op(input logic [7:0] c);
        cyc(1);
        i_opcode_valid = 1'b1;
        i_opcode = c;
        cyc(1);
        i_opcode_valid = 1'b0;
    endtask
    task automatic tmr_pulse;
        i_timer_overflow = 1'b1;
        cyc(1);
        i_timer_overflow = 1'b0;
    endtask
    task automatic wait_run;
        n = 0;
        while (o_core_reset !== 1'b0 && n < 200) begin
            cyc(1);
            n++;
        end
        cyc(3);
        chk(o_cpu_clk_en, 1'b1);
    endtask
    // Winner: highest level in priority order, then lowest source
    function automatic logic [6:0] pick(input logic [12:0] p);
        for (int l = 0; l < LEVEL_COUNT; l++)
            for (int k = 0; k < SRC_COUNT; k++)
                if (p[k] && i_level_map[2*k+:2] == i_interrupt_priority_register[2*l+:2])
                    return {1'b1, k[3:0], i_level_map[2*k+:2]};
        return 7'h00;
    endfunction
    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end
    initial begin
        repeat (20000) @(posedge i_clock);
        failures++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'h9961));
        {i_rst_n, i_opcode_valid, i_timer_overflow, i_irq_ack, i_opcode} = '0;
        {i_level_map, i_ext_irq_enable} = '0;
        {i_ce, i_interrupt_priority_register, i_stab_count} = {1'b1, 6'h24, 8'h04};
        repeat (10) @(posedge i_clock);
        cyc(1);
        i_rst_n = 1'b1;
        wait_run();
        chk(o_fetch_addr, RESET_FETCH_ADDR);
        repeat (20) begin
            for (int k = 0; k < SRC_COUNT; k++) i_level_map[2*k+:2] = 2'($urandom % 3);
            i_interrupt_priority_register = perm[$urandom % 6];
            i_ext_irq_enable = rpc_ext_irq_t'(12'($urandom));
            pend = 13'($urandom);
            pins.pulse_irq(pend[11:0]);
            i_timer_overflow = pend[12];
            cyc(1);
            i_timer_overflow = 1'b0;
            pend[11:0] = pend[11:0] & i_ext_irq_enable;
            cyc(2);
            for (int j = 0; j < 14; j++) begin
                e = pick(pend);
                chk(o_irq_valid, e[6]);
                if (!e[6]) break;
                chk({o_irq_source, o_irq_level}, e[5:0]);
                i_irq_ack = 1'b1;
                cyc(1);
                i_irq_ack = 1'b0;
                pend[e[5:2]] = 1'b0;
                cyc(2);
            end
        end
        n = 0;
        while (o_timer_tick !== 1'b1 && n < 1100) begin
            cyc(1);
            n++;
        end
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (o_timer_tick !== 1'b1 && n < 1100);
        chk(n, TMR_DIV);
        i_ce = 1'b0;
        op(OPC_STOP);
        i_ce = 1'b1;
        chk(o_state, RPC_RUN);
        foreach (lens[i]) begin
            seen = 1'b0;
            fork
                pins.hold_reset(lens[i]);
                repeat (lens[i] + 30) begin
                    cyc(1);
                    seen = seen | o_core_reset;
                end
            join
            chk(seen, lens[i] >= RST_MIN_LOW_CYCLES);
            wait_run();
        end
        repeat (3) begin
            i_ext_irq_enable = rpc_ext_irq_t'(12'h001 << ($urandom % 12));
            i_stab_count = 8'($urandom);
            op(OPC_STOP);
            chk({o_state, o_osc_enable}, {RPC_STOP, 1'b0});
            tmr_pulse();
            pins.pulse_irq(~i_ext_irq_enable);
            chk(o_state, RPC_STOP);
            pins.pulse_irq(i_ext_irq_enable);
            chk(o_timer_osc_src, 1'b1);
            n = 0;
            while (o_state === RPC_STAB && n < 300) begin
                cyc(1);
                n++;
            end
            chk(n, i_stab_count + 9'h001);
        end
        op(OPC_IDLE);
        chk({o_state, o_cpu_clk_en, o_periph_clk_en, o_port_dir_hold}, {RPC_IDLE, 3'h3});
        tmr_pulse();
        chk(o_state, RPC_RUN);
        op(OPC_IDLE);
        pins.pulse_irq(i_ext_irq_enable);
        chk(o_state, RPC_RUN);
        for (int j = 0; j < 2; j++) begin
            op(j ? OPC_STOP : OPC_IDLE);
            pins.hold_reset(30);
            chk(o_state, RPC_RUN);
            wait_run();
        end
        end_of_test();
    end
endmodule
